/* hdl/tts_map.vh */
// Register offsets, field positions, reset values and codes of the threshold trigger scope.
`ifndef TTS_MAP_VH
`define TTS_MAP_VH

`define TTS_REG_CTRL 8'h00
`define TTS_REG_THR_HI 8'h04
`define TTS_REG_THR_LO 8'h08
`define TTS_REG_WIN_LEN 8'h0c
`define TTS_REG_OFFSET 8'h10
`define TTS_REG_MARK1 8'h14
`define TTS_REG_MARK2 8'h18
`define TTS_REG_STATUS 8'h1c
`define TTS_REG_IRQ_STAT 8'h20
`define TTS_REG_IRQ_MASK 8'h24
`define TTS_REG_TSTAMP 8'h28
`define TTS_REG_ONSET_TS 8'h2c
`define TTS_REG_OFFSET_TS 8'h30
`define TTS_REG_TRIG_TS 8'h34
`define TTS_REG_SNIP_ADDR 8'h38
`define TTS_REG_SNIP_DATA 8'h3c

`define TTS_CTRL_FEAT_LSB 0
`define TTS_CTRL_CHAN_LSB 3
`define TTS_CTRL_DEBOUNCE 5
`define TTS_CTRL_HYST 6
`define TTS_CTRL_EN_SHOWN 7
`define TTS_CTRL_EN_MANUAL 8
`define TTS_CTRL_EPOCH_EN 9
`define TTS_CTRL_WAVE_EN 10
`define TTS_CTRL_W 11
`define TTS_CTRL_RST 11'h000

`define TTS_FEAT_ABOVE 3'h0
`define TTS_FEAT_BELOW 3'h1
`define TTS_FEAT_BETWEEN 3'h2
`define TTS_FEAT_OUTSIDE 3'h3
`define TTS_FEAT_RISING 3'h4
`define TTS_FEAT_FALLING 3'h5

`define TTS_IRQ_ONSET 0
`define TTS_IRQ_OFFSET 1
`define TTS_IRQ_TRIG 2
`define TTS_IRQ_SNIP 3
`define TTS_IRQ_REJECT 4
`define TTS_IRQ_W 5

`define TTS_DEBOUNCE_LEN 2'h3

`endif

/* hdl/tts_threshold_trigger.v */
// Threshold trigger unit: feature detection, trigger, strobe, delayed waveform and storage.
//
// Summary of operation
// - Feature is above, below, between, outside, rising or falling on the selected channel.
// - After reset the feature type is above threshold.
// - Four channels come in; one selected channel drives detection.
// - Hysteresis: false from marker 1 to crossing, true from crossing to marker 2.
// - A passing candidate pulses the trigger for exactly one clock cycle.
// - With hysteresis a candidate failing any condition gives no trigger.
// - Delayed waveform lags by window length plus offset.
// - With hysteresis the lag also adds the marker 2 interval.
// - Debounce: feature counts only after three consecutive true samples.
// - A shown enable control gates trigger and strobe until set.
// - A hidden enable control, the default, leaves trigger and strobe enabled.
// - Feature-state output is 1 while the feature holds, else 0.
// - Strobe rises with the trigger and stays high for the window.
// - Epoch storage keeps onset, offset and trigger timestamps.
// - Waveform storage keeps the first 64 samples of the window of every channel on each pass.
// - Threshold, window and offset may change while running.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`include "tts_map.vh"
`default_nettype none

module tts_threshold_trigger #(
  parameter DATA_W = 16,
  parameter AW = 6,
  parameter CNT_W = 16
) (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire sampleValid,
  input wire [DATA_W-1:0] sample0,
  input wire [DATA_W-1:0] sample1,
  input wire [DATA_W-1:0] sample2,
  input wire [DATA_W-1:0] sample3,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output wire [31:0] regRdata,
  output wire featureState,
  output wire trigger,
  output wire strobe,
  output wire [DATA_W-1:0] delayed_waveform_out,
  output wire irq
);

  localparam NCH = 4;
  localparam DEPTH = 1 << AW;
  localparam ST_IDLE = 1'b0;
  localparam ST_QUAL = 1'b1;

  reg [`TTS_CTRL_W-1:0] ctrl_ff;
  reg [DATA_W-1:0] thrHi_ff;
  reg [DATA_W-1:0] thrLo_ff;
  reg [CNT_W-1:0] winLen_ff;
  reg [CNT_W-1:0] offset_ff;
  reg [CNT_W-1:0] mark1_ff;
  reg [CNT_W-1:0] mark2_ff;
  reg [`TTS_IRQ_W-1:0] irqStat_ff;
  reg [`TTS_IRQ_W-1:0] irqMask_ff;
  reg [31:0] tstamp_ff;
  reg [31:0] onsetTs_ff;
  reg [31:0] offsetTs_ff;
  reg [31:0] trigTs_ff;
  reg [AW+1:0] snipAddr_ff;
  reg [31:0] regRdata_ff;
  reg irq_ff;

  reg [DATA_W-1:0] prevSel_ff;
  reg [1:0] runCnt_ff;
  reg featureState_ff;
  reg [CNT_W-1:0] falseRun_ff;
  reg [CNT_W-1:0] trueRun_ff;
  reg state_ff;
  reg trigger_ff;
  reg strobe_ff;
  reg [CNT_W-1:0] strobeCnt_ff;
  reg [AW-1:0] wrPtr_ff;
  reg [DATA_W-1:0] delayed_ff;

  wire tick = ce & sampleValid;
  wire [2:0] featType = ctrl_ff[`TTS_CTRL_FEAT_LSB +: 3];
  wire [1:0] chanSel = ctrl_ff[`TTS_CTRL_CHAN_LSB +: 2];
  wire debounceEn = ctrl_ff[`TTS_CTRL_DEBOUNCE];
  wire hystEn = ctrl_ff[`TTS_CTRL_HYST];
  wire epochEn = ctrl_ff[`TTS_CTRL_EPOCH_EN];
  wire waveEn = ctrl_ff[`TTS_CTRL_WAVE_EN];
  // A hidden enable control leaves trigger and strobe on; a shown one needs the manual bit.
  wire outEnable = ~ctrl_ff[`TTS_CTRL_EN_SHOWN] | ctrl_ff[`TTS_CTRL_EN_MANUAL];

  wire [NCH*DATA_W-1:0] sampleFlat = {sample3, sample2, sample1, sample0};
  wire [NCH*DATA_W-1:0] delayFlat;
  wire [NCH*DATA_W-1:0] snipFlat;
  wire signed [DATA_W-1:0] selSample = sampleFlat[chanSel*DATA_W +: DATA_W];
  wire signed [DATA_W-1:0] prevSel = prevSel_ff;
  wire signed [DATA_W-1:0] thrHi = thrHi_ff;
  wire signed [DATA_W-1:0] thrLo = thrLo_ff;

  reg rawFeature;
  always @* begin
    case (featType)
      `TTS_FEAT_ABOVE: rawFeature = selSample > thrHi;
      `TTS_FEAT_BELOW: rawFeature = selSample < thrHi;
      `TTS_FEAT_BETWEEN: rawFeature = (selSample < thrHi) && (selSample > thrLo);
      `TTS_FEAT_OUTSIDE: rawFeature = (selSample > thrHi) || (selSample < thrLo);
      `TTS_FEAT_RISING: rawFeature = selSample > prevSel;
      `TTS_FEAT_FALLING: rawFeature = selSample < prevSel;
      default: rawFeature = 1'b0;
    endcase
  end

  // The current true sample plus two already counted make three in a row.
  wire featNow = debounceEn ?
    (rawFeature && (runCnt_ff >= (`TTS_DEBOUNCE_LEN - 2'h1))) : rawFeature;
  wire crossing = featNow & ~featureState_ff;
  wire falling = ~featNow & featureState_ff;

  // Candidate qualification and the firing decision.
  reg nxtState;
  reg [CNT_W-1:0] nxtTrueRun;
  reg pass;
  reg reject;
  always @* begin
    nxtState = state_ff;
    nxtTrueRun = trueRun_ff;
    pass = 1'b0;
    reject = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (crossing) begin
          if (!hystEn) begin
            pass = 1'b1;
          end else if (falseRun_ff < mark1_ff) begin
            reject = 1'b1;
          end else if (mark2_ff == {CNT_W{1'b0}}) begin
            pass = 1'b1;
          end else begin
            nxtState = ST_QUAL;
            nxtTrueRun = {CNT_W{1'b0}};
          end
        end
      end
      ST_QUAL: begin
        if (!featNow) begin
          reject = 1'b1;
          nxtState = ST_IDLE;
        end else if (trueRun_ff + {{(CNT_W-1){1'b0}}, 1'b1} >= mark2_ff) begin
          pass = 1'b1;
          nxtState = ST_IDLE;
        end else begin
          nxtTrueRun = trueRun_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: nxtState = ST_IDLE;
    endcase
  end

  wire fire = pass & outEnable;

  // Strobe covers exactly the samples of the capture window; a new pass restarts it.
  reg nxtStrobe;
  reg [CNT_W-1:0] nxtStrobeCnt;
  always @* begin
    nxtStrobe = strobe_ff;
    nxtStrobeCnt = strobeCnt_ff;
    if (fire) begin
      nxtStrobe = winLen_ff != {CNT_W{1'b0}};
      nxtStrobeCnt = {CNT_W{1'b0}};
    end else if (strobe_ff) begin
      nxtStrobeCnt = strobeCnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      nxtStrobe = nxtStrobeCnt < winLen_ff;
    end
  end

  wire snipWr = tick & waveEn & nxtStrobe & (nxtStrobeCnt < DEPTH);
  wire [AW-1:0] snipIdx = nxtStrobeCnt[AW-1:0];

  // Delay lengths beyond the history depth saturate at the oldest stored sample.
  wire [CNT_W+1:0] delaySum = {2'b00, winLen_ff} + {2'b00, offset_ff}
    + (hystEn ? {2'b00, mark2_ff} : {(CNT_W+2){1'b0}});
  wire [AW-1:0] delayClamp = (delaySum > DEPTH - 1) ? {AW{1'b1}} : delaySum[AW-1:0];
  wire [AW-1:0] rdPtr = wrPtr_ff - delayClamp;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : chan
      reg [DATA_W-1:0] hist [0:DEPTH-1];
      reg [DATA_W-1:0] snip [0:DEPTH-1];
      integer k;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          for (k = 0; k < DEPTH; k = k + 1) begin
            hist[k] <= {DATA_W{1'b0}};
            snip[k] <= {DATA_W{1'b0}};
          end
        end else if (tick) begin
          hist[wrPtr_ff] <= sampleFlat[gi*DATA_W +: DATA_W];
          if (snipWr) begin
            snip[snipIdx] <= delayFlat[gi*DATA_W +: DATA_W];
          end
        end
      end
      assign delayFlat[gi*DATA_W +: DATA_W] = (delayClamp == {AW{1'b0}}) ?
        sampleFlat[gi*DATA_W +: DATA_W] : hist[rdPtr];
      assign snipFlat[gi*DATA_W +: DATA_W] = snip[snipAddr_ff[AW-1:0]];
    end
  endgenerate

  // Sample-rate detection path.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevSel_ff <= {DATA_W{1'b0}};
      runCnt_ff <= 2'h0;
      featureState_ff <= 1'b0;
      falseRun_ff <= {CNT_W{1'b0}};
      trueRun_ff <= {CNT_W{1'b0}};
      state_ff <= ST_IDLE;
      trigger_ff <= 1'b0;
      strobe_ff <= 1'b0;
      strobeCnt_ff <= {CNT_W{1'b0}};
      wrPtr_ff <= {AW{1'b0}};
      delayed_ff <= {DATA_W{1'b0}};
      tstamp_ff <= 32'h0000_0000;
      onsetTs_ff <= 32'h0000_0000;
      offsetTs_ff <= 32'h0000_0000;
      trigTs_ff <= 32'h0000_0000;
    end else if (ce) begin
      trigger_ff <= tick & fire;
      if (tick) begin
        prevSel_ff <= selSample;
        if (!rawFeature) begin
          runCnt_ff <= 2'h0;
        end else if (runCnt_ff != `TTS_DEBOUNCE_LEN) begin
          runCnt_ff <= runCnt_ff + 2'h1;
        end
        featureState_ff <= featNow;
        if (featNow) begin
          falseRun_ff <= {CNT_W{1'b0}};
        end else if (falseRun_ff != {CNT_W{1'b1}}) begin
          falseRun_ff <= falseRun_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        state_ff <= nxtState;
        trueRun_ff <= nxtTrueRun;
        strobe_ff <= nxtStrobe;
        strobeCnt_ff <= nxtStrobeCnt;
        wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
        delayed_ff <= delayFlat[chanSel*DATA_W +: DATA_W];
        tstamp_ff <= tstamp_ff + 32'h0000_0001;
        if (epochEn && crossing) begin
          onsetTs_ff <= tstamp_ff;
        end
        if (epochEn && falling) begin
          offsetTs_ff <= tstamp_ff;
        end
        if (epochEn && fire) begin
          trigTs_ff <= tstamp_ff;
        end
      end
      if (!outEnable) strobe_ff <= 1'b0;
    end
  end

  wire [`TTS_IRQ_W-1:0] irqEvent = tick ? {reject, strobe_ff & ~nxtStrobe & waveEn,
    fire, falling, crossing} : {`TTS_IRQ_W{1'b0}};
  wire wrHit = ce & regWr;

  // Register writes; an event in the clearing cycle keeps its status bit set.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= `TTS_CTRL_RST;
      thrHi_ff <= {DATA_W{1'b0}};
      thrLo_ff <= {DATA_W{1'b0}};
      winLen_ff <= {CNT_W{1'b0}};
      offset_ff <= {CNT_W{1'b0}};
      mark1_ff <= {CNT_W{1'b0}};
      mark2_ff <= {CNT_W{1'b0}};
      irqStat_ff <= {`TTS_IRQ_W{1'b0}};
      irqMask_ff <= {`TTS_IRQ_W{1'b0}};
      snipAddr_ff <= {(AW+2){1'b0}};
      irq_ff <= 1'b0;
    end else if (ce) begin
      if (wrHit) begin
        case (regAddr)
          `TTS_REG_CTRL: ctrl_ff <= regWdata[`TTS_CTRL_W-1:0];
          `TTS_REG_THR_HI: thrHi_ff <= regWdata[DATA_W-1:0];
          `TTS_REG_THR_LO: thrLo_ff <= regWdata[DATA_W-1:0];
          `TTS_REG_WIN_LEN: winLen_ff <= regWdata[CNT_W-1:0];
          `TTS_REG_OFFSET: offset_ff <= regWdata[CNT_W-1:0];
          `TTS_REG_MARK1: mark1_ff <= regWdata[CNT_W-1:0];
          `TTS_REG_MARK2: mark2_ff <= regWdata[CNT_W-1:0];
          `TTS_REG_IRQ_MASK: irqMask_ff <= regWdata[`TTS_IRQ_W-1:0];
          `TTS_REG_SNIP_ADDR: snipAddr_ff <= regWdata[AW+1:0];
          default: ;
        endcase
      end
      if (wrHit && regAddr == `TTS_REG_IRQ_STAT) begin
        irqStat_ff <= (irqStat_ff & ~regWdata[`TTS_IRQ_W-1:0]) | irqEvent;
      end else begin
        irqStat_ff <= irqStat_ff | irqEvent;
      end
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  wire [DATA_W-1:0] snipWord = snipFlat[snipAddr_ff[AW+1:AW]*DATA_W +: DATA_W];
  reg [31:0] rdValue;
  always @* begin
    case (regAddr)
      `TTS_REG_CTRL: rdValue = {{(32-`TTS_CTRL_W){1'b0}}, ctrl_ff};
      `TTS_REG_THR_HI: rdValue = {{(32-DATA_W){thrHi_ff[DATA_W-1]}}, thrHi_ff};
      `TTS_REG_THR_LO: rdValue = {{(32-DATA_W){thrLo_ff[DATA_W-1]}}, thrLo_ff};
      `TTS_REG_WIN_LEN: rdValue = {{(32-CNT_W){1'b0}}, winLen_ff};
      `TTS_REG_OFFSET: rdValue = {{(32-CNT_W){1'b0}}, offset_ff};
      `TTS_REG_MARK1: rdValue = {{(32-CNT_W){1'b0}}, mark1_ff};
      `TTS_REG_MARK2: rdValue = {{(32-CNT_W){1'b0}}, mark2_ff};
      `TTS_REG_STATUS: rdValue = {27'h0000000, outEnable, state_ff, strobe_ff, trigger_ff,
        featureState_ff};
      `TTS_REG_IRQ_STAT: rdValue = {{(32-`TTS_IRQ_W){1'b0}}, irqStat_ff};
      `TTS_REG_IRQ_MASK: rdValue = {{(32-`TTS_IRQ_W){1'b0}}, irqMask_ff};
      `TTS_REG_TSTAMP: rdValue = tstamp_ff;
      `TTS_REG_ONSET_TS: rdValue = onsetTs_ff;
      `TTS_REG_OFFSET_TS: rdValue = offsetTs_ff;
      `TTS_REG_TRIG_TS: rdValue = trigTs_ff;
      `TTS_REG_SNIP_ADDR: rdValue = {{(30-AW){1'b0}}, snipAddr_ff};
      `TTS_REG_SNIP_DATA: rdValue = {{(32-DATA_W){snipWord[DATA_W-1]}}, snipWord};
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // Read data stand for one cycle only, so a stale word is never mistaken for a new one.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      regRdata_ff <= regRd ? rdValue : 32'h0000_0000;
    end
  end

  assign regRdata = regRdata_ff;
  assign featureState = featureState_ff;
  assign trigger = trigger_ff;
  assign strobe = strobe_ff;
  assign delayed_waveform_out = delayed_ff;
  assign irq = irq_ff;

endmodule

`default_nettype wire

/* sim/tts_threshold_trigger_monitor.sv */
// Port-level assertions for the threshold trigger unit.
`timescale 1ns/1ns
`include "tts_map.vh"
`default_nettype none
module tts_threshold_trigger_monitor #(
  parameter DATA_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sampleValid,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic featureState,
  input wire logic trigger,
  input wire logic strobe,
  input wire logic [DATA_W-1:0] delayed_waveform_out
);
  logic [10:0] ctrl_ff;
  logic gate;
  // The control shadow updates on the same edge as the unit's own copy, so modes line up.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= 11'h000;
    end else if (regWr && regAddr == `TTS_REG_CTRL) begin
      ctrl_ff <= regWdata[10:0];
    end
  end
  assign gate = ctrl_ff[7] && !ctrl_ff[8];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  trig_pulse_a: assert property (trigger |=> !trigger)
    else $error("trigger wider than one cycle");
  strobe_start_a: assert property ($rose(strobe) |-> trigger)
    else $error("strobe rose without trigger");
  trig_feat_a: assert property (trigger |-> featureState)
    else $error("trigger while feature false");
  trig_tick_a: assert property (trigger |-> $past(sampleValid))
    else $error("trigger without a sample");
  feat_tick_a: assert property (!$past(sampleValid) |-> $stable(featureState))
    else $error("feature state moved without a sample");
  wave_tick_a: assert property (!$past(sampleValid) |-> $stable(delayed_waveform_out))
    else $error("delayed waveform moved without a sample");
  rise_trig_a: assert property ($rose(featureState) && !ctrl_ff[6] && !gate |-> trigger)
    else $error("feature onset gave no trigger");
  gate_hold_a: assert property (gate && $past(gate) |-> !trigger && !strobe)
    else $error("output active while disabled");
  cover property (trigger && ctrl_ff[6]);
  cover property ($fell(strobe));
  cover property (gate && featureState);
endmodule
bind tts_threshold_trigger tts_threshold_trigger_monitor #(.DATA_W(DATA_W)) MON (
  .clk(clk), .nrst(nrst), .sampleValid(sampleValid), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .featureState(featureState),
  .trigger(trigger), .strobe(strobe), .delayed_waveform_out(delayed_waveform_out));
`default_nettype wire

/* sim/tts_sample_src.sv */
// Upstream sample source model feeding the four input channels.
`timescale 1ns/1ns
`default_nettype none
module tts_sample_src (
  input wire logic clk,
  output logic sampleValid,
  output logic [15:0] sample0,
  output logic [15:0] sample1,
  output logic [15:0] sample2,
  output logic [15:0] sample3
);
  initial begin
    sampleValid = 1'b0;
    {sample0, sample1, sample2, sample3} = '0;
  end
  // Each channel carries a different view of the value, so a wrong channel choice shows.
  task automatic send(input logic [15:0] x, input int gap);
    @(posedge clk);
    sampleValid <= 1'b1;
    {sample0, sample1, sample2, sample3} <= {x, x + 16'h0064, -x, ~x};
    @(posedge clk);
    sampleValid <= 1'b0;
    // Lines are not held after the sample, so a late read sees garbage, not the old value.
    {sample0, sample1, sample2, sample3} <= {~x, x, x, x};
    repeat (gap) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* sim/tts_threshold_trigger_tb.sv */
// Self-checking bench for the threshold trigger unit.
`timescale 1ns/1ns
`include "tts_map.vh"
`default_nettype none
module tts_threshold_trigger_tb;
  typedef struct packed {logic [10:0] ctl; logic [15:0] pre; logic [15:0] x;
    logic f; logic t;} tts_row_t;
  logic clk, nrst, regWr, regRd, sampleValid, featureState, trigger, strobe, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rv, t0;
  logic [15:0] s0, s1, s2, s3, dly;
  logic [15:0] hist [$];
  logic [11:0] hb = 12'he9c;
  logic [6:0] db = 7'h76;
  int n_mismatch = 0;
  int checks = 0;
  int d;
  tts_row_t rows [7] = '{
    '{11'h000, 16'h0000, 16'h0014, 1'b1, 1'b1},
    '{11'h001, 16'h0000, 16'hffec, 1'b1, 1'b0},
    '{11'h002, 16'h0014, 16'h000a, 1'b0, 1'b0},
    '{11'h003, 16'h0000, 16'hfff5, 1'b1, 1'b1},
    '{11'h004, 16'hfff5, 16'h0006, 1'b1, 1'b1},
    '{11'h005, 16'h0006, 16'h0005, 1'b1, 1'b1},
    '{11'h010, 16'h0000, 16'hffec, 1'b1, 1'b1}};
  tts_threshold_trigger DUT (.clk(clk), .nrst(nrst), .ce(1'b1), .sampleValid(sampleValid),
    .sample0(s0), .sample1(s1), .sample2(s2), .sample3(s3), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .featureState(featureState), .trigger(trigger), .strobe(strobe),
    .delayed_waveform_out(dly), .irq(irq));
  tts_sample_src SRC (.clk(clk), .sampleValid(sampleValid), .sample0(s0), .sample1(s1),
    .sample2(s2), .sample3(s3));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {regWr, regAddr, regWdata} <= {1'b1, a, v};
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask
  task automatic tk(input logic [15:0] x, input int gap);
    hist.push_back(x);
    SRC.send(x, gap);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {nrst, regWr, regRd, regAddr, regWdata} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(`TTS_REG_CTRL);
    chk(rv, 32'h0);
    chk(32'({featureState, trigger, strobe, irq}), 32'h0);
    wr(`TTS_REG_THR_HI, 32'ha);
    wr(`TTS_REG_THR_LO, 32'hfffffff6);
    foreach (rows[i]) begin
      wr(`TTS_REG_CTRL, 32'(rows[i].ctl));
      tk(rows[i].pre, 0);
      tk(rows[i].x, 0);
      chk(32'(featureState), 32'(rows[i].f));
      chk(32'(trigger), 32'(rows[i].t));
    end
    wr(`TTS_REG_WIN_LEN, 32'h3);
    wr(`TTS_REG_OFFSET, 32'h1);
    wr(`TTS_REG_CTRL, 32'h0);
    tk(16'h0, 0);
    d = 4;
    for (int i = 0; i < 12; i++) begin
      if (i == 8) begin
        wr(`TTS_REG_OFFSET, 32'h0);
        d = 3;
      end
      tk(16'(i * 7), 0);
      chk(32'(strobe), 32'(i >= 2 && i <= 4));
      chk(32'(trigger), 32'(i == 2));
      if (i >= 5) chk(32'(dly), 32'(hist[hist.size() - 1 - d]));
    end
    wr(`TTS_REG_MARK1, 32'h2);
    wr(`TTS_REG_MARK2, 32'h2);
    wr(`TTS_REG_WIN_LEN, 32'h1);
    wr(`TTS_REG_IRQ_MASK, 32'h10);
    wr(`TTS_REG_CTRL, 32'h40);
    for (int i = 0; i < 12; i++) begin
      tk(hb[i] ? 16'(50 + i) : 16'(i), 0);
      chk(32'(featureState), 32'(hb[i]));
      chk(32'(trigger), 32'(i == 4));
      chk(32'(dly), 32'(hist[hist.size() - 4]));
    end
    chk(32'(irq), 32'h1);
    wr(`TTS_REG_IRQ_MASK, 32'h0);
    rd(`TTS_REG_IRQ_STAT);
    chk(32'({rv[4], irq}), 32'h2);
    wr(`TTS_REG_IRQ_STAT, 32'h10);
    wr(`TTS_REG_IRQ_MASK, 32'h10);
    rd(`TTS_REG_IRQ_STAT);
    chk(32'({rv[4], irq}), 32'h0);
    wr(`TTS_REG_CTRL, 32'h20);
    for (int i = 0; i < 7; i++) begin
      tk(db[i] ? 16'h20 : 16'h0, 1);
      chk(32'(featureState), 32'(i == 6));
    end
    wr(`TTS_REG_CTRL, 32'h280);
    tk(16'h0, 0);
    tk(16'h20, 0);
    chk(32'({featureState, trigger, strobe}), 32'h4);
    wr(`TTS_REG_CTRL, 32'h380);
    tk(16'h0, 0);
    rd(`TTS_REG_TSTAMP);
    t0 = rv;
    tk(16'h20, 0);
    chk(32'({trigger, strobe}), 32'h3);
    rd(`TTS_REG_TRIG_TS);
    chk(rv, t0);
    complete_run();
  end
endmodule
`default_nettype wire
